// File: logic/char_fifo.sv
// small fifo of received characters with a registered read port
// assumes synchronous active-low reset and one clock
module char_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	char_stream_if.snk fill,
	char_stream_if.src drain
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // storage words
	logic [AW-1:0] wr_ptr; // next slot to write
	logic [AW-1:0] rd_ptr; // next slot to read
	logic [AW:0] count; // words in storage
	logic push; // fill handshake
	logic pop; // storage to output register
	logic out_valid; // output register holds a word
	logic [WIDTH-1:0] out_data; // output register
	// honest full: ready drops only when every slot is taken
	assign fill.ready = (count != (AW+1)'(DEPTH));
	assign push = fill.valid && fill.ready;
	assign pop = (count != '0) && (!out_valid || drain.ready);
	assign drain.valid = out_valid;
	assign drain.data = out_data;
	// storage writes, no reset needed on data
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= fill.data;
		end
	end
	// pointers and occupancy
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			// simultaneous push and pop leaves the count alone
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
	// registered read port, refilled as soon as it empties
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (pop) begin
			out_valid <= 1'b1;
			out_data <= mem[rd_ptr];
		end else if (drain.ready) begin
			out_valid <= 1'b0;
		end
	end
endmodule

// File: logic/char_stream_if.sv
// valid/ready word stream between the receiver and its fifo
// assumes both ends share one clock
interface char_stream_if #(parameter int WIDTH = 8);
	logic valid; // word offered
	logic ready; // word accepted when both high
	logic [WIDTH-1:0] data; // word itself
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// File: logic/serial_rx_and_output_ports.sv
// serial start/stop receiver on one input line, six input ports
// and sixteen strobed output ports sharing one data bus
// assumes inputs synchronous to clock, latches outside take the bus
//
// Overview of operation
// - line high is mark, low space
// - serial bit selectable, defaults to top bit
// - steady mark keeps receiver idle, polling
// - space while idle starts a character
// - sample at programmable bit period intervals
// - sample near middle of each cell
// - shift samples in arrival order, mark one
// - stop bit found by counting bits
// - after stop, return to idle polling
// - each output port: eight data, one strobe
// - one shared output bus for all ports
// - strobe alone selects the receiving port
// - addressed port strobed while bus valid
// - standard ports ten to seventeen decoded
// - expanded ports twenty to twenty-seven too
// - six input ports read in parallel
module serial_rx_and_output_ports (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [47:0] in_lines,
	input wire logic in_read,
	input wire logic [2:0] in_sel,
	output logic [7:0] in_data,
	output logic in_done,
	input wire logic [2:0] rx_port_sel,
	input wire logic [2:0] rx_bit_sel,
	input wire logic [15:0] bit_period,
	input wire logic [3:0] char_len,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic frame_err,
	output logic overrun,
	input wire logic err_clear,
	input wire logic out_write,
	input wire logic [7:0] out_addr,
	input wire logic [7:0] out_value,
	input wire logic expand_en,
	output logic [7:0] out_bus,
	output logic [15:0] out_strobe
);
	// reset release path
	logic rst_meta; // first stage, read only by rst_sync
	logic rst_sync; // second stage

	// receiver state
	sio_pkg::rx_state_t state; // receiver phase
	logic [15:0] timer; // cycles left to the next sample
	logic [3:0] bits_got; // data bits collected so far
	logic [7:0] shift; // character being assembled
	logic [3:0] len; // length latched at the start bit
	logic [7:0] rx_word; // port that carries the serial line
	logic line; // chosen serial line
	logic [15:0] per; // bit period in force, never zero
	logic [15:0] half; // cycles from start edge to mid start bit
	logic tick; // timer reached its sample point
	logic stop_ok; // stop sample was a mark
	logic stop_seen; // stop sample taken this cycle

	// fifo between receiver and reader
	char_stream_if #(.WIDTH(sio_pkg::DATA_W)) rx_in ();
	char_stream_if #(.WIDTH(sio_pkg::DATA_W)) rx_out ();

	// output decode
	logic [15:0] next_strobe; // one-hot strobe for this write

	// picks one eight-line port out of the packed input lines
	function automatic logic [7:0] port_slice(
		input logic [47:0] lines,
		input logic [2:0] sel
	);
		logic [7:0] r;
		r = 8'h00;
		// out-of-range ports read as zero
		if (sel <= sio_pkg::IN_SEL_W_MAX) begin
			r = lines[sel*8 +: 8];
		end
		return r;
	endfunction

	// turns an output address into a one-hot strobe, or none
	function automatic logic [15:0] strobe_of(
		input logic [7:0] addr,
		input logic exp
	);
		logic [15:0] r;
		logic [7:0] idx;
		r = 16'h0000;
		idx = addr - sio_pkg::OUT_STD_FIRST;
		if (addr >= sio_pkg::OUT_STD_FIRST && addr <= sio_pkg::OUT_STD_LAST) begin
			r[idx[3:0]] = 1'b1;
		end else if (exp && addr >= sio_pkg::OUT_EXP_FIRST
				&& addr <= sio_pkg::OUT_EXP_LAST) begin
			r[idx[3:0]] = 1'b1;
		end
		return r;
	endfunction

	// cycles per bit, a zero period replaced by the safe fallback
	function automatic logic [15:0] period_of(
		input logic [15:0] p
	);
		logic [15:0] r;
		r = p;
		// zero would wrap the timer reload and stall the receiver
		if (p == 16'h0000) begin
			r = sio_pkg::BIT_PERIOD_RESET;
		end
		return r;
	endfunction

	// asynchronous assert, two-flop release
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// serial line pick: any port, any bit, top bit by default wiring
	// whole port first, then the chosen bit of it
	assign rx_word = port_slice(in_lines, rx_port_sel);
	assign line = rx_word[rx_bit_sel];
	assign per = period_of(bit_period);
	assign half = per >> 1;
	assign tick = (timer == 16'h0000);
	assign stop_seen = (state == sio_pkg::RX_STOP) && tick;
	assign stop_ok = (line == sio_pkg::MARK);

	// receiver sequencer
	always_ff @(posedge clock) begin
		if (!rst_sync) begin
			state <= sio_pkg::RX_IDLE;
		end else begin
			case (state)
				sio_pkg::RX_IDLE: begin
					// steady mark: keep polling, nothing starts
					if (line == sio_pkg::SPACE) begin
						state <= sio_pkg::RX_START;
					end
				end
				sio_pkg::RX_START: begin
					// recheck at mid start bit; a glitch goes back idle
					if (tick) begin
						if (line == sio_pkg::SPACE) begin
							state <= sio_pkg::RX_DATA;
						end else begin
							state <= sio_pkg::RX_IDLE;
						end
					end
				end
				sio_pkg::RX_DATA: begin
					// bit count, not the line, decides the stop bit
					if (tick && (bits_got + 4'h1 == len)) begin
						state <= sio_pkg::RX_STOP;
					end
				end
				sio_pkg::RX_STOP: begin
					if (tick) begin
						state <= sio_pkg::RX_IDLE;
					end
				end
				default: begin
					state <= sio_pkg::RX_IDLE;
				end
			endcase
		end
	end

	// bit timer: half a period to mid start, then whole periods
	always_ff @(posedge clock) begin
		if (!rst_sync) begin
			timer <= 16'h0000;
		end else if (state == sio_pkg::RX_IDLE) begin
			// half period lands every later sample mid cell
			if (half == 16'h0000) begin
				timer <= 16'h0000; // one-cycle period: no room for a half
			end else begin
				timer <= half - 16'h0001;
			end
		end else if (tick) begin
			// a period changed mid frame takes effect at the next sample
			timer <= per - 16'h0001;
		end else begin
			timer <= timer - 16'h0001;
		end
	end

	// character length latched at each start so changes mid frame are safe
	always_ff @(posedge clock) begin
		if (!rst_sync) begin
			len <= sio_pkg::CHAR_LEN_MAX;
		end else if (state == sio_pkg::RX_IDLE) begin
			if (char_len < sio_pkg::CHAR_LEN_MIN) begin
				len <= sio_pkg::CHAR_LEN_MIN;
			end else if (char_len > sio_pkg::CHAR_LEN_MAX) begin
				len <= sio_pkg::CHAR_LEN_MAX;
			end else begin
				len <= char_len;
			end
		end
	end

	// data shifter: first bit in ends up lowest after alignment
	always_ff @(posedge clock) begin
		if (!rst_sync) begin
			shift <= 8'h00;
			bits_got <= 4'h0;
		end else if (state == sio_pkg::RX_IDLE) begin
			shift <= 8'h00;
			bits_got <= 4'h0;
		end else if (state == sio_pkg::RX_DATA && tick) begin
			shift <= {line, shift[7:1]};
			bits_got <= bits_got + 4'h1;
		end
	end

	// finished character offered to the fifo on a marking stop
	assign rx_in.valid = stop_seen && stop_ok;
	assign rx_in.data = shift >> (4'h8 - len);

	// error flags: set wins over a clear in the same cycle
	always_ff @(posedge clock) begin
		if (!rst_sync) begin
			frame_err <= 1'b0;
			overrun <= 1'b0;
		end else begin
			if (stop_seen && !stop_ok) begin
				frame_err <= 1'b1;
			end else if (err_clear) begin
				frame_err <= 1'b0;
			end
			// full fifo: the character is lost, not the older ones
			if (rx_in.valid && !rx_in.ready) begin
				overrun <= 1'b1;
			end else if (err_clear) begin
				overrun <= 1'b0;
			end
		end
	end

	// nine-character buffer between receiver and reader: eight slots plus the output register
	char_fifo #(
		.WIDTH(sio_pkg::DATA_W),
		.DEPTH(sio_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.rst_n(rst_sync),
		.fill(rx_in),
		.drain(rx_out)
	);

	// reader side: valid doubles as the character-ready flag
	assign rx_data = rx_out.data;
	assign rx_valid = rx_out.valid;
	assign rx_out.ready = rx_ready;

	// parallel input read: all eight lines in one sample
	always_ff @(posedge clock) begin
		if (!rst_sync) begin
			in_data <= 8'h00;
			in_done <= 1'b0;
		end else begin
			in_done <= in_read;
			if (in_read) begin
				in_data <= port_slice(in_lines, in_sel);
			end
		end
	end

	// one-hot decode guarantees a single port per write
	assign next_strobe = out_write ? strobe_of(out_addr, expand_en) : 16'h0000;

	// shared bus and strobes launched on the same edge
	always_ff @(posedge clock) begin
		if (!rst_sync) begin
			out_bus <= 8'h00;
		end else if (next_strobe != 16'h0000) begin
			// bus holds after the strobe so latches see stable data
			out_bus <= out_value;
		end
	end

	// strobe is the decode registered each cycle, high for as long as a decoded write is held
	always_ff @(posedge clock) begin
		if (!rst_sync) begin
			out_strobe <= 16'h0000;
		end else begin
			out_strobe <= next_strobe;
		end
	end
endmodule

// File: logic/sio_pkg.sv
// constants shared by the serial receiver, output ports and fifo
// assumes a single 50 MHz clock and a synchronous reset copy
package sio_pkg;
	localparam int DATA_W = 8; // width of every port and of the bus
	localparam int IN_PORTS = 6; // input ports 0 to 5
	localparam logic [2:0] IN_SEL_W_MAX = 3'h5; // highest input port
	localparam logic [2:0] TOP_PORT_BIT = 3'h7; // default serial line bit
	localparam logic [2:0] RX_PORT_RESET = 3'h0; // default serial port
	localparam int STROBES = 16; // standard plus expanded ports
	localparam logic [7:0] OUT_STD_FIRST = 8'h08; // port 10 octal
	localparam logic [7:0] OUT_STD_LAST = 8'h0f; // port 17 octal
	localparam logic [7:0] OUT_EXP_FIRST = 8'h10; // port 20 octal
	localparam logic [7:0] OUT_EXP_LAST = 8'h17; // port 27 octal
	localparam logic [3:0] CHAR_LEN_MIN = 4'h5; // five-level code
	localparam logic [3:0] CHAR_LEN_MAX = 4'h8; // eight-level code
	localparam logic [15:0] BIT_PERIOD_RESET = 16'h0004; // fallback period
	localparam int FIFO_DEPTH = 8; // received characters held
	localparam logic MARK = 1'b1; // marking line level
	localparam logic SPACE = 1'b0; // spacing line level
	typedef enum logic [1:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP
	} rx_state_t;
endpackage

// File: test/serial_rx_and_output_ports_properties.sv
// port checks for the receiver and output ports block
// assumes the bind below and an asynchronous active-low reset
module serial_rx_and_output_ports_properties (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [47:0] in_lines,
	input wire logic in_read,
	input wire logic [2:0] in_sel,
	input wire logic [7:0] in_data,
	input wire logic in_done,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire logic frame_err,
	input wire logic err_clear,
	input wire logic out_write,
	input wire logic [7:0] out_addr,
	input wire logic [7:0] out_value,
	input wire logic expand_en,
	input wire logic [7:0] out_bus,
	input wire logic [15:0] out_strobe
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	a_read_sample: assert property (in_read && in_sel <= 3'h5 |=>
		in_done && in_data == $past(in_lines[in_sel * 8 +: 8])) else $error("bad read");
	a_std_decode: assert property (out_write && out_addr >= 8'h08 && out_addr <= 8'h0f |=>
		out_strobe == 16'h0001 << ($past(out_addr) - 8'h08)) else $error("bad strobe");
	a_exp_gated: assert property (out_write && out_addr[7:3] == 5'h02 && !expand_en |=>
		out_strobe == 16'h0000) else $error("strobe while unexpanded");
	a_exp_decode: assert property (out_write && out_addr[7:3] == 5'h02 && expand_en |=>
		out_strobe == 16'h0100 << $past(out_addr[2:0])) else $error("bad expanded strobe");
	a_strobe_cause: assert property (out_strobe != 16'h0000 |->
		$past(out_write) && out_bus == $past(out_value)) else $error("strobe without write");
	a_strobe_single: assert property ($onehot0(out_strobe)) else $error("two strobes");
	a_bus_holds: assert property (!out_write |=> $stable(out_bus)) else $error("bus moved");
	a_head_holds: assert property (rx_valid && !rx_ready |=>
		rx_valid && $stable(rx_data)) else $error("head lost");
	a_frame_sticky: assert property (frame_err && !err_clear |=> frame_err)
		else $error("frame flag dropped");
	// main scenarios reached
	cover property (out_write && out_addr[4] && expand_en);
	cover property (rx_valid && rx_ready);
	cover property ($rose(frame_err));
endmodule
bind serial_rx_and_output_ports serial_rx_and_output_ports_properties u_props (
	.clock(clock), .arst_n(arst_n), .in_lines(in_lines), .in_read(in_read),
	.in_sel(in_sel), .in_data(in_data), .in_done(in_done), .rx_data(rx_data),
	.rx_valid(rx_valid), .rx_ready(rx_ready), .frame_err(frame_err),
	.err_clear(err_clear), .out_write(out_write), .out_addr(out_addr),
	.out_value(out_value), .expand_en(expand_en), .out_bus(out_bus),
	.out_strobe(out_strobe));

// File: test/serial_rx_and_output_ports_test.sv
// self-checking bench for the receiver and output ports
// assumes the package, checker and partner model compile first
module serial_rx_and_output_ports_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, arst_n, in_read, rx_ready, err_clear, out_write, expand_en, line;
	logic in_done, rx_valid, frame_err, overrun;
	logic [47:0] in_rand, in_lines;
	logic [2:0] in_sel, rx_port_sel, rx_bit_sel;
	logic [15:0] bit_period, out_strobe;
	logic [3:0] char_len;
	logic [7:0] in_data, rx_data, out_addr, out_value, out_bus, bus_hold;
	int seed = 32'h0000_d81c;
	int err_total = 0;
	int total_checks = 0;
	int cycles = 0;
	logic [7:0] sent [$]; // characters awaiting read-back
	// the serial line replaces one chosen input bit
	always_comb begin
		in_lines = in_rand;
		in_lines[rx_port_sel * 8 + rx_bit_sel] = line;
	end
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	serial_rx_and_output_ports u_serial_rx_and_output_ports (.clock(clock), .arst_n(arst_n),
		.in_lines(in_lines), .in_read(in_read), .in_sel(in_sel), .in_data(in_data),
		.in_done(in_done), .rx_port_sel(rx_port_sel), .rx_bit_sel(rx_bit_sel),
		.bit_period(bit_period), .char_len(char_len), .rx_data(rx_data),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .frame_err(frame_err), .overrun(overrun),
		.err_clear(err_clear), .out_write(out_write), .out_addr(out_addr),
		.out_value(out_value), .expand_en(expand_en), .out_bus(out_bus),
		.out_strobe(out_strobe));
	teleprinter_model u_teleprinter_model (.clock(clock), .out_bus(out_bus),
		.out_strobe(out_strobe), .line(line));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// a hang counts as a mismatch
	always @(posedge clock) begin
		cycles++;
		if (cycles == 50000) begin
			err_total++;
			stop_test();
		end
	end
	function automatic logic [15:0] strobe_for(input logic [7:0] a, input logic ex);
		if ((a >= 8'h08 && a <= 8'h0f) || (ex && a >= 8'h10 && a <= 8'h17)) begin
			return 16'h0001 << (a - 8'h08);
		end
		return 16'h0000;
	endfunction
	// one output instruction, then strobe, bus and latch
	task automatic write_port(input logic [7:0] a, input logic [7:0] v);
		logic [15:0] s;
		s = strobe_for(a, expand_en);
		@(posedge clock);
		#1 out_write = 1'b1;
		out_addr = a;
		out_value = v;
		@(posedge clock);
		#1 out_write = 1'b0;
		if (s != 16'h0000) bus_hold = v;
		check(out_strobe, s);
		check(out_bus, bus_hold);
		@(posedge clock);
		#1 check(out_strobe, 16'h0000);
		if (s != 16'h0000) check(u_teleprinter_model.latch[a - 8'h08], v);
	endtask
	// parallel read of one input port with fresh random lines
	task automatic read_port(input logic [2:0] p);
		logic [7:0] e;
		@(posedge clock);
		#1 in_rand = {16'($random(seed)), 32'($random(seed))};
		in_read = 1'b1;
		in_sel = p;
		@(posedge clock);
		e = (p <= 3'h5) ? in_lines[p * 8 +: 8] : 8'h00;
		#1 in_read = 1'b0;
		check(in_done, 1'b1);
		check(in_data, e);
	endtask
	// wait for the head character, compare it, accept it
	task automatic take_char(input logic [7:0] e);
		int n;
		n = 0;
		// an edge passes first so ready never toggles twice in one step
		do begin
			@(posedge clock);
			#1 n++;
		end while (rx_valid !== 1'b1 && n < 400);
		check(rx_valid, 1'b1);
		check(rx_data, e);
		rx_ready = 1'b1;
		@(posedge clock);
		#1 rx_ready = 1'b0;
	endtask
	initial begin
		{arst_n, in_read, rx_ready, err_clear, out_write, expand_en} = 6'h00;
		{in_rand, in_sel, rx_port_sel, out_addr, out_value, bus_hold} = 0;
		rx_bit_sel = 3'h7;
		bit_period = 16'h0008;
		char_len = 4'h8;
		repeat (4) @(posedge clock);
		#1 arst_n = 1'b1;
		repeat (3) @(posedge clock);
		#1 check(rx_valid, 1'b0);
		for (int p = 0; p < 8; p++) read_port(3'(p));
		// decoded ports plus neighbours, expansion off then on
		for (int x = 0; x < 2; x++) begin
			expand_en = 1'(x);
			for (int a = 7; a <= 24; a++) write_port(8'(a), 8'($random(seed)));
		end
		// lengths five to eight on random lines, last at the fallback period
		for (int k = 0; k < 8; k++) begin
			logic [7:0] c;
			c = 8'($random(seed));
			char_len = 4'(5 + k % 4);
			rx_port_sel = 3'(k % 6);
			rx_bit_sel = 3'($random(seed));
			bit_period = (k == 7) ? 16'h0000 : 16'h0008;
			u_teleprinter_model.send(c, 5 + k % 4, (k == 7) ? 4 : 8, 1'b1);
			take_char(c & ~(8'hff << (5 + k % 4)));
		end
		bit_period = 16'h0008;
		u_teleprinter_model.blip(2);
		repeat (40) @(posedge clock);
		#1 check(rx_valid, 1'b0);
		u_teleprinter_model.send(8'h5a, 8, 8, 1'b0);
		check(frame_err, 1'b1);
		check(rx_valid, 1'b0);
		err_clear = 1'b1;
		@(posedge clock);
		#1 err_clear = 1'b0;
		check(frame_err, 1'b0);
		// fill past capacity with the reader stalled, then drain
		for (int k = 0; k < 10; k++) begin
			sent.push_back(8'($random(seed)));
			u_teleprinter_model.send(sent[k], 8, 8, 1'b1);
		end
		check(overrun, 1'b1);
		for (int k = 0; k < 9; k++) take_char(sent[k]);
		@(posedge clock);
		#1 check(rx_valid, 1'b0);
		stop_test();
	end
endmodule

// File: test/teleprinter_model.sv
// transmitter loop on the serial line and the external port latches
// assumes the line changes 1 ns after a rising clock edge
module teleprinter_model (
	input wire logic clock,
	input wire logic [7:0] out_bus,
	input wire logic [15:0] out_strobe,
	output logic line
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] latch [16]; // one latch per strobed port
	initial line = sio_pkg::MARK; // loop closed while idle
	// each latch takes the shared bus on its own strobe only
	always_ff @(posedge clock) begin
		for (int i = 0; i < 16; i++) begin
			if (out_strobe[i]) begin
				latch[i] <= out_bus;
			end
		end
	end
	// start, data first bit first, stop; per is cycles per bit
	task automatic send(input logic [7:0] ch, input int len, input int per, input logic stop);
		logic [9:0] frame;
		frame = {1'b0, ch, 1'b0};
		frame[len + 1] = stop;
		for (int k = 0; k < len + 2; k++) begin
			@(posedge clock);
			#1 line = frame[k];
			repeat (per - 1) @(posedge clock);
		end
		@(posedge clock);
		#1 line = sio_pkg::MARK;
	endtask
	// short space, too brief to be a start bit
	task automatic blip(input int n);
		@(posedge clock);
		#1 line = sio_pkg::SPACE;
		repeat (n) @(posedge clock);
		#1 line = sio_pkg::MARK;
	endtask
endmodule
